// ### dv/crb_checker.sv
// port-level assertions for the comparator register bank
// assumes bound onto crb_bank with hready fed from hreadyout
`timescale 1ns/100ps
module crb_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic comparator_out,
  input wire logic ladder_on,
  input wire logic ladder_range,
  input wire logic [3:0] ladder_tap,
  input wire logic [3:0] reference_tap,
  input wire logic reference_ground,
  input wire logic [5:0] reference_numer,
  input wire logic [5:0] reference_denom,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // address phase accepted at one word offset
  sequence s_req(logic [7:0] off, logic wr);
    hsel && hready && htrans[1] && hwrite == wr && haddr[7:2] == off[7:2];
  endsequence
  // write address phase, then its data phase
  sequence s_wr(logic [7:0] off);
    s_req(off, 1'b1) ##1 1'b1;
  endsequence
  property p_on; s_wr(8'h10) |=> ladder_on == $past(hwdata[9]); endproperty
  a_on: assert property (p_on)
    else $error("ladder power bit not taken from write");
  property p_rng; s_wr(8'h10) |=> ladder_range == $past(hwdata[8]); endproperty
  a_rng: assert property (p_rng)
    else $error("ladder range bit not taken from write");
  property p_tap; s_wr(8'h10) |=> ladder_tap == $past(hwdata[3:0]); endproperty
  a_tap: assert property (p_tap)
    else $error("ladder tap not taken from write");
  property p_gnd;
    reference_ground == !ladder_on
      && reference_tap == (ladder_on ? ladder_tap : 4'h0);
  endproperty
  a_gnd: assert property (p_gnd)
    else $error("reference not grounded with ladder off");
  property p_num;
    ladder_on |->
      reference_numer == {2'h0, ladder_tap} + (ladder_range ? 6'h00 : 6'h08);
  endproperty
  a_num: assert property (p_num)
    else $error("ladder tap position wrong");
  property p_den;
    reference_denom == (ladder_range ? 6'h18 : 6'h20);
  endproperty
  a_den: assert property (p_den)
    else $error("ladder total wrong");
  property p_rsv;
    s_req(8'h10, 1'b0) |=> (hrdata & 32'hFFFF_FCF0) == 32'h0000_0000
      && hrdata[3:0] == ladder_tap
      && hrdata[9:8] == {ladder_on, ladder_range};
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reference control read back wrong");
  property p_mis; s_req(8'h00, 1'b0) ##0 irq |=> hrdata[0]; endproperty
  a_mis: assert property (p_mis)
    else $error("masked status misses pending interrupt");
  property p_ris; s_req(8'h04, 1'b0) ##0 irq |=> hrdata[0]; endproperty
  a_ris: assert property (p_ris)
    else $error("raw status misses pending interrupt");
  property p_ien; s_wr(8'h08) ##0 !hwdata[0] |=> !irq; endproperty
  a_ien: assert property (p_ien)
    else $error("interrupt not masked by cleared enable");
  property p_stat;
    $stable(comparator_out) [*7] ##0 s_req(8'h20, 1'b0)
      |=> hrdata[1] == $past(comparator_out);
  endproperty
  a_stat: assert property (p_stat)
    else $error("status does not show comparator output");
endmodule

// ### dv/tb_top.sv
// self-checking bench for crb_bank over AHB-Lite word transfers
// assumes a single master, hready looped back from hreadyout
`timescale 1ns/100ps
`define chk(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  bad_count++; $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = crb_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic comparator_out = 1'b0;
  logic hready, hreadyout, hresp, ladder_on, ladder_range;
  logic reference_ground, irq;
  logic [31:0] hrdata, rd;
  logic [3:0] ladder_tap, reference_tap;
  logic [5:0] reference_numer, reference_denom, e_num;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] vals [4] = '{32'hFFFF_FFFF, 32'h0000_020C, 32'h0000_010C,
                            32'h0000_0000};
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  crb_bank i_crb_bank (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .comparator_out(comparator_out), .ladder_on(ladder_on),
    .ladder_range(ladder_range), .ladder_tap(ladder_tap),
    .reference_tap(reference_tap), .reference_ground(reference_ground),
    .reference_numer(reference_numer), .reference_denom(reference_denom),
    .irq(irq));
  task automatic tally_and_finish;
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= crb_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    `chk(rd, e)
    `chk(hresp, 1'b0)
    `chk(hreadyout, 1'b1)
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `chk(reference_ground, 1'b1)
    `chk(reference_denom, 6'h20)
    rd_chk(8'h10, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000);
    bus(8'h14, 1'b1, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h0000_0000);
    foreach (vals[i]) begin
      bus(8'h10, 1'b1, vals[i]);
      rd_chk(8'h10, vals[i] & 32'h0000_030F);
      e_num = {2'h0, vals[i][3:0]} + (vals[i][8] ? 6'h00 : 6'h08);
      if (!vals[i][9]) e_num = 6'h00;
      `chk(ladder_on, vals[i][9])
      `chk(ladder_range, vals[i][8])
      `chk(ladder_tap, vals[i][3:0])
      `chk(reference_tap, vals[i][9] ? vals[i][3:0] : 4'h0)
      `chk(reference_numer, e_num)
      `chk(reference_denom, vals[i][8] ? 6'h18 : 6'h20)
    end
    bus(8'h20, 1'b1, 32'hFFFF_FFFF);
    rd_chk(8'h20, 32'h0000_0000);
    bus(8'h04, 1'b1, 32'hFFFF_FFFF);
    rd_chk(8'h04, 32'h0000_0000);
    comparator_out <= 1'b1;
    repeat (8) @(posedge hclk);
    rd_chk(8'h20, 32'h0000_0002);
    `chk(irq, 1'b0)
    rd_chk(8'h04, 32'h0000_0001);
    rd_chk(8'h04, 32'h0000_0000);
    bus(8'h08, 1'b1, 32'hFFFF_FFFF);
    rd_chk(8'h08, 32'h0000_0001);
    comparator_out <= 1'b0;
    repeat (8) @(posedge hclk);
    `chk(irq, 1'b1)
    rd_chk(8'h00, 32'h0000_0001);
    `chk(irq, 1'b0)
    comparator_out <= 1'b1;
    repeat (8) @(posedge hclk);
    bus(8'h08, 1'b1, 32'h0000_0000);
    rd_chk(8'h08, 32'h0000_0000);
    `chk(irq, 1'b0)
    rd_chk(8'h04, 32'h0000_0001);
    bus(8'h08, 1'b1, 32'h0000_0001);
    bus(8'h0C, 1'b1, 32'hFFFF_FFFD);
    rd_chk(8'h0C, 32'h0000_0001);
    comparator_out <= 1'b0;
    repeat (8) @(posedge hclk);
    `chk(irq, 1'b1)
    rd_chk(8'h04, 32'h0000_0001);
    comparator_out <= 1'b1;
    repeat (8) @(posedge hclk);
    rd_chk(8'h04, 32'h0000_0000);
    bus(8'h0C, 1'b1, 32'h0000_0002);
    comparator_out <= 1'b0;
    repeat (8) @(posedge hclk);
    `chk(irq, 1'b0)
    comparator_out <= 1'b1;
    repeat (8) @(posedge hclk);
    `chk(irq, 1'b1)
    rd_chk(8'h00, 32'h0000_0001);
    bus(8'h0C, 1'b1, 32'h0000_0003);
    rd_chk(8'h04, 32'h0000_0001);
    rd_chk(8'h04, 32'h0000_0001);
    comparator_out <= 1'b0;
    repeat (8) @(posedge hclk);
    rd_chk(8'h04, 32'h0000_0001);
    rd_chk(8'h04, 32'h0000_0000);
    bus(8'h10, 1'b1, 32'h0000_030C);
    hresetn <= 1'b0;
    comparator_out <= 1'b1;
    repeat (2) @(posedge hclk);
    `chk(ladder_on, 1'b0)
    `chk(reference_ground, 1'b1)
    `chk(irq, 1'b0)
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
    rd_chk(8'h04, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
    rd_chk(8'h20, 32'h0000_0002);
    tally_and_finish();
  end
endmodule
bind crb_bank crb_checker i_crb_checker (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .comparator_out(comparator_out),
  .ladder_on(ladder_on), .ladder_range(ladder_range),
  .ladder_tap(ladder_tap), .reference_tap(reference_tap),
  .reference_ground(reference_ground), .reference_numer(reference_numer),
  .reference_denom(reference_denom), .irq(irq));

// ### include/crb_pkg.sv
// constants of the comparator register bank: offsets, fields, resets
// assumes a 32-bit AHB-Lite bus, one slave, word accesses only
//
// Behaviour
// - offset 0x00 reads interrupt status masked by the enable.
// - offset 0x04 reads raw interrupt status, ignoring the enable.
// - offset 0x08 holds the interrupt enable gating raw into masked.
// - reference control at 0x10, bit 9 powers the resistor ladder.
// - reference control bit 8 selects the ladder range.
// - reference control bits 3:0 pick the ladder tap for the reference.
// - offset 0x20 is read-only and shows the synchronised, filtered comparator output.
// - with the ladder unpowered the reference is ground, any tap.
// - range clear gives 32 units of ladder, range set gives 24 units.
package crb_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_MASKED_INT_STATUS = 8'h00;
  localparam logic [7:0] OFF_RAW_INT_STATUS = 8'h04;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h08;
  localparam logic [7:0] OFF_INT_SENSE = 8'h0C;
  localparam logic [7:0] OFF_REFERENCE_CONTROL = 8'h10;
  localparam logic [7:0] OFF_COMPARATOR_OUTPUT_STATUS = 8'h20;

  localparam int unsigned INT_BIT = 0;
  localparam int unsigned OUT_VALUE_BIT = 1;
  localparam int unsigned LADDER_ON_BIT = 9;
  localparam int unsigned LADDER_RANGE_BIT = 8;
  localparam int unsigned TAP_MSB = 3;
  localparam int unsigned TAP_LSB = 0;
  localparam int unsigned SENSE_MSB = 1;
  localparam int unsigned SENSE_LSB = 0;

  localparam logic [31:0] REFERENCE_CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] INT_ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] INT_SENSE_RESET = 32'h0000_0000;
  localparam logic [31:0] REFERENCE_CONTROL_MASK = 32'h0000_030F;
  localparam logic [31:0] INT_ENABLE_MASK = 32'h0000_0001;
  localparam logic [31:0] INT_SENSE_MASK = 32'h0000_0003;

  localparam logic [1:0] SENSE_ANY_EDGE = 2'h0;
  localparam logic [1:0] SENSE_FALLING = 2'h1;
  localparam logic [1:0] SENSE_RISING = 2'h2;
  localparam logic [1:0] SENSE_LEVEL_HIGH = 2'h3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  localparam logic [5:0] LADDER_TOTAL_FULL = 6'h20;
  localparam logic [5:0] LADDER_TOTAL_SHORT = 6'h18;
  localparam logic [5:0] LADDER_BASE_FULL = 6'h08;
  localparam logic [5:0] LADDER_BASE_SHORT = 6'h00;

  // tap position over total: the reference is avdd * numer / denom
  function automatic logic [11:0] ladder_ratio(input logic on,
                                               input logic range,
                                               input logic [3:0] tap);
    logic [5:0] numer;
    logic [5:0] denom;
    numer = range ? (LADDER_BASE_SHORT + {2'h0, tap}) :
                    (LADDER_BASE_FULL + {2'h0, tap});
    denom = range ? LADDER_TOTAL_SHORT : LADDER_TOTAL_FULL;
    if (!on) begin
      numer = 6'h00;
    end
    return {numer, denom};
  endfunction
endpackage

// ### include/crb_sync_if.sv
// carrier between the bank and its comparator-output synchroniser
// assumes the raw level comes from the analog comparator, any timing
`timescale 1ns/100ps
interface crb_sync_if;
  logic raw_in;
  logic level;
  logic changed;
  modport sync (input raw_in, output level, output changed);
  modport user (output raw_in, input level, input changed);
endinterface

// ### verilog/crb_bank.sv
// comparator register bank: AHB-Lite slave, interrupt and ladder control
// assumes one AHB-Lite master, word transfers, comparator output async
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps
module crb_bank (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic comparator_out,
  output logic ladder_on,
  output logic ladder_range,
  output logic [3:0] ladder_tap,
  output logic [3:0] reference_tap,
  output logic reference_ground,
  output logic [5:0] reference_numer,
  output logic [5:0] reference_denom,
  output logic irq
);
  crb_sync_if sync_if ();

  logic [31:0] reference_control;
  logic [31:0] int_enable;
  logic [31:0] int_sense;
  logic raw_int;
  logic [31:0] hrdata_q;
  logic wr_pending;
  logic [7:0] wr_addr;

  logic [31:0] next_reference_control;
  logic [31:0] next_int_enable;
  logic [31:0] next_int_sense;
  logic next_raw_int;
  logic addr_phase;
  logic rd_accept;
  logic wr_accept;
  logic [7:0] word_addr;
  logic read_clears;
  logic event_hit;
  logic [11:0] ratio;

  assign sync_if.raw_in = comparator_out;

  crb_out_sync u_out_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .port_if(sync_if)
  );

  // register write with a per-bit mask of the live bits
  function automatic logic [31:0] merge_write(input logic [31:0] cur,
                                              input logic [31:0] wdata,
                                              input logic [31:0] mask);
    return (cur & ~mask) | (wdata & mask);
  endfunction

  // true for an offset that lands on one of the bank's words
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      crb_pkg::OFF_MASKED_INT_STATUS,
      crb_pkg::OFF_RAW_INT_STATUS,
      crb_pkg::OFF_INT_ENABLE,
      crb_pkg::OFF_INT_SENSE,
      crb_pkg::OFF_REFERENCE_CONTROL,
      crb_pkg::OFF_COMPARATOR_OUTPUT_STATUS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ---------------- bus address phase ----------------
  always_comb begin
    addr_phase = hsel && hready &&
                 ((htrans == crb_pkg::HTRANS_NONSEQ) ||
                  (htrans == crb_pkg::HTRANS_SEQ));
    rd_accept = addr_phase && !hwrite;
    wr_accept = addr_phase && hwrite;
    word_addr = {haddr[7:2], 2'b00};
  end

  // a read of either status word clears the sticky bit
  always_comb begin
    read_clears = rd_accept &&
                  ((word_addr == crb_pkg::OFF_MASKED_INT_STATUS) ||
                   (word_addr == crb_pkg::OFF_RAW_INT_STATUS));
  end

  // data phase of a write is pending for one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pending <= wr_accept;
      if (wr_accept) begin
        wr_addr <= word_addr;
      end
    end
  end

  // ---------------- register next values ----------------
  always_comb begin
    next_reference_control = reference_control;
    next_int_enable = int_enable;
    next_int_sense = int_sense;
    if (wr_pending) begin
      case (wr_addr)
        crb_pkg::OFF_REFERENCE_CONTROL: begin
          // reserved bits never take a written value
          next_reference_control = merge_write(reference_control, hwdata,
            crb_pkg::REFERENCE_CONTROL_MASK);
        end
        crb_pkg::OFF_INT_ENABLE: begin
          next_int_enable = merge_write(int_enable, hwdata,
                                        crb_pkg::INT_ENABLE_MASK);
        end
        crb_pkg::OFF_INT_SENSE: begin
          next_int_sense = merge_write(int_sense, hwdata,
                                       crb_pkg::INT_SENSE_MASK);
        end
        default: begin
          next_int_sense = int_sense;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reference_control <= crb_pkg::REFERENCE_CONTROL_RESET;
    end else begin
      reference_control <= next_reference_control;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_enable <= crb_pkg::INT_ENABLE_RESET;
      int_sense <= crb_pkg::INT_SENSE_RESET;
    end else begin
      int_enable <= next_int_enable;
      int_sense <= next_int_sense;
    end
  end

  // ---------------- comparator events ----------------
  always_comb begin
    case (int_sense[crb_pkg::SENSE_MSB:crb_pkg::SENSE_LSB])
      crb_pkg::SENSE_ANY_EDGE: event_hit = sync_if.changed;
      crb_pkg::SENSE_FALLING: event_hit = sync_if.changed && !sync_if.level;
      crb_pkg::SENSE_RISING: event_hit = sync_if.changed && sync_if.level;
      crb_pkg::SENSE_LEVEL_HIGH: event_hit = sync_if.level;
      default: event_hit = 1'b0;
    endcase
  end

  // sticky raw bit: a new event wins over the read-clear
  always_comb begin
    if (event_hit) begin
      next_raw_int = 1'b1;
    end else if (read_clears) begin
      next_raw_int = 1'b0;
    end else begin
      next_raw_int = raw_int;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_int <= 1'b0;
    end else begin
      raw_int <= next_raw_int;
    end
  end

  // ---------------- read data ----------------
  // read data is picked at the address phase from the values that hold
  // after this edge, so a write just before is already seen
  function automatic logic [31:0] read_word(input logic [7:0] addr,
                                            input logic raw_bit,
                                            input logic [31:0] enable,
                                            input logic [31:0] sense,
                                            input logic [31:0] refctl,
                                            input logic out_bit);
    logic [31:0] word;
    word = 32'h0000_0000;
    case (addr)
      crb_pkg::OFF_MASKED_INT_STATUS: begin
        word[crb_pkg::INT_BIT] = raw_bit &&
                                 enable[crb_pkg::INT_BIT];
      end
      crb_pkg::OFF_RAW_INT_STATUS: begin
        word[crb_pkg::INT_BIT] = raw_bit;
      end
      crb_pkg::OFF_INT_ENABLE: begin
        word = enable & crb_pkg::INT_ENABLE_MASK;
      end
      crb_pkg::OFF_INT_SENSE: begin
        word = sense & crb_pkg::INT_SENSE_MASK;
      end
      crb_pkg::OFF_REFERENCE_CONTROL: begin
        word = refctl & crb_pkg::REFERENCE_CONTROL_MASK;
      end
      crb_pkg::OFF_COMPARATOR_OUTPUT_STATUS: begin
        word[crb_pkg::OUT_VALUE_BIT] = out_bit;
      end
      default: begin
        word = 32'h0000_0000;
      end
    endcase
    return word;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_accept) begin
      if (is_mapped(word_addr)) begin
        hrdata_q <= read_word(word_addr, raw_int || event_hit,
                              next_int_enable, next_int_sense,
                              next_reference_control, sync_if.level);
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  // zero-wait slave, every transfer answered OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // ---------------- ladder and reference ----------------
  always_comb begin
    ladder_on = reference_control[crb_pkg::LADDER_ON_BIT];
    ladder_range = reference_control[crb_pkg::LADDER_RANGE_BIT];
    ladder_tap =
      reference_control[crb_pkg::TAP_MSB:crb_pkg::TAP_LSB];
  end

  // unpowered ladder leaves the reference at ground
  always_comb begin
    reference_ground = !ladder_on;
    reference_tap = ladder_on ? ladder_tap : 4'h0;
    ratio = crb_pkg::ladder_ratio(ladder_on, ladder_range,
                                  ladder_tap);
    reference_numer = ratio[11:6];
    reference_denom = ratio[5:0];
  end

  // ---------------- interrupt ----------------
  assign irq = raw_int && int_enable[crb_pkg::INT_BIT];
endmodule

// ### verilog/crb_out_sync.sv
// three-flop synchroniser with agreement filter for the comparator output
// assumes raw_in is asynchronous to hclk
`timescale 1ns/100ps
module crb_out_sync (
  input wire logic hclk,
  input wire logic hresetn,
  crb_sync_if.sync port_if
);
  logic stage1;
  logic stage2;
  logic stage3;
  logic level_q;
  logic changed_q;
  logic [3:0] warm_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= port_if.raw_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // pin level settling after reset is the start level, not a change
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      warm_q <= 4'h0;
    end else begin
      warm_q <= {warm_q[2:0], 1'b1};
    end
  end

  // a change counts once the second and third flops agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_q <= 1'b0;
      changed_q <= 1'b0;
    end else begin
      changed_q <= warm_q[3] && (stage2 == stage3) &&
                   (stage3 != level_q);
      if (stage2 == stage3) begin
        level_q <= stage3;
      end
    end
  end

  assign port_if.level = level_q;
  assign port_if.changed = changed_q;
endmodule
